// ===== irq_source_model.sv
// Model of the interrupt sources and frequency loop beside the control block
`timescale 1ns/10ps

module irq_source_model #(
	parameter int LOCK_CYCLES = 8
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [8:0] pin_req,
	input  wire logic       irq_req,
	input  wire logic       pll_run,
	output logic [8:0]      ext_pin,
	output logic            periph_irq,
	output logic            pll_lock
);
	int lock_cnt;

	always_ff @(posedge aclk) begin
		ext_pin    <= pin_req;
		periph_irq <= irq_req;
	end

	// Lock drops at once when the loop stops, never held stale
	always_ff @(posedge aclk) begin
		if (!aresetn || !pll_run) begin
			lock_cnt <= 0;
			pll_lock <= 1'h0;
		end else if (lock_cnt < LOCK_CYCLES) begin
			lock_cnt <= lock_cnt + 1;
		end else begin
			pll_lock <= 1'h1;
		end
	end
endmodule

// ===== sys_ctrl_pkg.sv
// Shared constants, types and register map of the system control block
package sys_ctrl_pkg;

	localparam int              ADDR_W          = 6;
	localparam int              N_IRQ_LINES     = 4;

	localparam logic [ADDR_W-1:0] OFF_EXT_MODE    = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_EXT_FLAG    = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_EXT_WAKE    = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_EXT_ROUTE   = 6'h0C;
	localparam logic [ADDR_W-1:0] OFF_VECTOR_MAP  = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_POWER_MODE  = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_PERIPH_GATE = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_PCLK_DIV    = 6'h1C;
	localparam logic [ADDR_W-1:0] OFF_PLL_CTRL    = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_PROT_STATUS = 6'h24;
	localparam logic [ADDR_W-1:0] OFF_BOOT_REQ    = 6'h28;

	localparam int              IDLE_BIT        = 0;
	localparam int              DOWN_BIT        = 1;
	localparam int              PLL_EN_BIT      = 0;
	localparam int              PLL_CONNECT_BIT = 1;

	localparam logic [1:0]      RESP_OKAY       = 2'h0;
	localparam logic [1:0]      RESP_SLVERR     = 2'h2;

	localparam logic [1:0]      DIV_QUARTER     = 2'h0;
	localparam logic [1:0]      DIV_ONE         = 2'h1;
	localparam logic [1:0]      DIV_TWO         = 2'h2;
	localparam logic [1:0]      TERM_ONE        = 2'h0;
	localparam logic [1:0]      TERM_TWO        = 2'h1;
	localparam logic [1:0]      TERM_QUARTER    = 2'h3;

	typedef enum logic [1:0] {
		LVL_NONE  = 2'b00,
		LVL_ONE   = 2'b01,
		LVL_TWO   = 2'b10,
		LVL_THREE = 2'b11
	} prot_level_t;

	typedef enum logic [1:0] {
		PWR_RUN  = 2'b00,
		PWR_IDLE = 2'b01,
		PWR_DOWN = 2'b10,
		PWR_WAKE = 2'b11
	} power_state_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic bus_clk_en;
		logic osc_en;
		logic pll_run;
		logic pins_hold;
	} clock_gate_t;

	typedef struct packed {
		logic debug_en;
		logic isp_en;
		logic isp_sector0_locked;
		logic isp_erase_only;
		logic boot_pin_honored;
		logic iap_en;
	} access_t;

endpackage

// ===== system_power_protect_ctrl.sv
// System control: code protection, external interrupts, vector map, power and clock control
// Contract
// - Protection level decoded from flash pattern word
// - In-application flash programming never blocked
// - Level one: no debug, no sector 0
// - Level two: no debug, erase-all only
// - Level three: no debug, boot, pin
// - Level three still honours application boot request
// - Nine edge/level pins onto four lines
// - Enabled external pins wake from power-down
// - Vector area maps to flash or SRAM
// - Idle halts execution until reset/interrupt
// - Peripheral clocks keep running during idle
// - Idle stops processor, memory and bus clocks
// - Power-down stops oscillator and all clocks
// - Power-down retains state, holds output pins
// - Power-down left on reset or clockless interrupt
// - Individual software clock gate per peripheral
// - Peripheral clock divides core by 1/2/4
// - Peripheral divider resets to quarter rate
// - Frequency loop kept running through idle
// - Wake from power-down passes the wake-up timer; idle exits straight to run
// - Loop off and bypassed after reset
`timescale 1ns/10ps

module system_power_protect_ctrl
	import sys_ctrl_pkg::*;
#(
	parameter int          N_EXT         = 9,
	parameter int          N_PERIPH      = 16,
	parameter int          WAKE_CYCLES   = 16,
	parameter logic [31:0] PATTERN_ONE   = 32'h1111_1111,
	parameter logic [31:0] PATTERN_TWO   = 32'h2222_2222,
	parameter logic [31:0] PATTERN_THREE = 32'h3333_3333
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [ADDR_W-1:0]       awaddr,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output logic                         wready,
	output logic [1:0]                   bresp,
	output logic                         bvalid,
	input  wire logic                    bready,
	input  wire logic [ADDR_W-1:0]       araddr,
	input  wire logic                    arvalid,
	output logic                         arready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output logic                         rvalid,
	input  wire logic                    rready,
	input  wire logic [N_EXT-1:0]        ext_pin,
	input  wire logic                    periph_irq,
	input  wire logic [31:0]             flash_protect_word,
	input  wire logic                    flash_word_valid,
	input  wire logic                    boot_entry_pin,
	input  wire logic                    pll_lock,
	output logic [N_IRQ_LINES-1:0]       ext_irq,
	output clock_gate_t                  clock_gate,
	output logic [N_PERIPH-1:0]          periph_clk_gate,
	output logic                         pclk_en,
	output logic                         core_clk_from_pll,
	output logic                         vectors_in_sram,
	output access_t                      access,
	output logic                         boot_loader_entry
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	logic [N_EXT-1:0]    ext_mode;
	logic [N_EXT-1:0]    ext_flag;
	logic [N_EXT-1:0]    ext_wake;
	logic [2*N_EXT-1:0]  ext_route;
	logic [N_EXT-1:0]    ext_prev;
	logic [1:0]          power_mode;
	logic [N_PERIPH-1:0] periph_gate;
	logic [1:0]          pclk_div;
	logic [1:0]          pll_ctrl;
	logic                boot_request;
	prot_level_t         level;
	logic                prot_valid;
	power_state_t        state;
	power_state_t        next_state;
	logic [15:0]         wake_cnt;
	logic [1:0]          pclk_cnt;
	logic [1:0]          pclk_active;
	logic                aw_got;
	logic                w_got;
	logic [ADDR_W-1:0]   aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                wr_fire;
	logic [31:0]         rd_word;
	logic                rd_err;
	logic                any_irq;
	logic                wake_req;
	logic                periph_run;
	logic [31:0]         flag_clr;
	logic [N_EXT-1:0]    edge_hit;

	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
		return wr_fire && (aw_addr == off);
	endfunction

	function automatic logic [31:0] merged(input logic [31:0] old);
		return apply_strb(old, w_data, w_strb);
	endfunction

	function automatic prot_level_t decode_level(input logic [31:0] word);
		if (word == PATTERN_THREE) begin
			return LVL_THREE;
		end else if (word == PATTERN_TWO) begin
			return LVL_TWO;
		end else if (word == PATTERN_ONE) begin
			return LVL_ONE;
		end
		return LVL_NONE;
	endfunction

	function automatic logic [1:0] div_terminal(input logic [1:0] sel);
		unique case (sel)
			DIV_ONE: return TERM_ONE;
			DIV_TWO: return TERM_TWO;
			default: return TERM_QUARTER;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave; address and data accepted in either order

	assign awready = !aw_got && !bvalid;
	assign wready  = !w_got && !bvalid;
	assign arready = !rvalid;
	assign wr_fire = aw_got && w_got && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_got  <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_got  <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= (aw_addr > OFF_BOOT_REQ || aw_addr[1:0] != 2'h0 ||
					aw_addr == OFF_PROT_STATUS) ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = '0;
		rd_err  = 1'b0;
		unique case (araddr)
			OFF_EXT_MODE:    rd_word = 32'(ext_mode);
			OFF_EXT_FLAG:    rd_word = 32'(ext_flag);
			OFF_EXT_WAKE:    rd_word = 32'(ext_wake);
			OFF_EXT_ROUTE:   rd_word = 32'(ext_route);
			OFF_VECTOR_MAP:  rd_word = 32'(vectors_in_sram);
			OFF_POWER_MODE:  rd_word = 32'({state, power_mode});
			OFF_PERIPH_GATE: rd_word = 32'(periph_gate);
			OFF_PCLK_DIV:    rd_word = 32'(pclk_div);
			OFF_PLL_CTRL:    rd_word = 32'({pll_lock, pll_ctrl});
			OFF_PROT_STATUS: rd_word = 32'({access, boot_loader_entry, prot_valid, level});
			OFF_BOOT_REQ:    rd_word = 32'(boot_request);
			default:         rd_err  = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_mode        <= '0;
			ext_wake        <= '0;
			ext_route       <= '0;
			vectors_in_sram <= 1'b0;
			periph_gate     <= '1;
			pclk_div        <= DIV_QUARTER;
			pll_ctrl        <= '0;
		end else begin
			if (wr_hit(OFF_EXT_MODE))
				ext_mode <= N_EXT'(merged(32'(ext_mode)));
			if (wr_hit(OFF_EXT_WAKE))
				ext_wake <= N_EXT'(merged(32'(ext_wake)));
			if (wr_hit(OFF_EXT_ROUTE))
				ext_route <= (2*N_EXT)'(merged(32'(ext_route)));
			if (wr_hit(OFF_VECTOR_MAP))
				vectors_in_sram <= 1'(merged(32'(vectors_in_sram)));
			if (wr_hit(OFF_PERIPH_GATE))
				periph_gate <= N_PERIPH'(merged(32'(periph_gate)));
			if (wr_hit(OFF_PCLK_DIV))
				pclk_div <= 2'(merged(32'(pclk_div)));
			if (wr_hit(OFF_PLL_CTRL))
				pll_ctrl <= 2'(merged(32'(pll_ctrl)));
		end
	end

	// Loop only feeds the core once enabled, connected and locked
	assign core_clk_from_pll = pll_ctrl[PLL_EN_BIT] && pll_ctrl[PLL_CONNECT_BIT] && pll_lock;

	////////////////////////////////////////////////////////////////////////////////
	// Code read protection

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level             <= LVL_NONE;
			prot_valid        <= 1'b0;
			boot_loader_entry <= 1'b0;
		end else begin
			if (flash_word_valid && !prot_valid) begin
				level      <= decode_level(flash_protect_word);
				prot_valid <= 1'b1;
				// Strap caught once, at the first protection read after reset
				if (boot_entry_pin && decode_level(flash_protect_word) != LVL_THREE)
					boot_loader_entry <= 1'b1;
			end
			if (prot_valid && boot_request)
				boot_loader_entry <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_request <= 1'b0;
		end else if (wr_hit(OFF_BOOT_REQ)) begin
			boot_request <= 1'(merged(32'(boot_request)));
		end
	end

	// Until the pattern is read all but IAP stays locked, unless software requests boot
	always_comb begin
		access                    = '0;
		access.iap_en             = 1'b1;
		access.debug_en           = prot_valid && level == LVL_NONE;
		access.isp_en             = (prot_valid && level != LVL_THREE) || boot_request;
		access.isp_sector0_locked = level == LVL_ONE;
		access.isp_erase_only     = level == LVL_TWO;
		access.boot_pin_honored   = prot_valid && level != LVL_THREE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// External interrupt inputs

	// Write-one-clear mask and rising edges of the pins
	assign flag_clr = apply_strb(32'h0, w_data, w_strb);
	assign edge_hit = ext_mode & ext_pin & ~ext_prev;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_prev <= '0;
			ext_flag <= '0;
		end else begin
			ext_prev <= ext_pin;
			for (int i = 0; i < N_EXT; i++) begin
				if (wr_hit(OFF_EXT_FLAG) && flag_clr[i])
					ext_flag[i] <= 1'b0;
				// Set after the clear so a same-cycle event is kept
				if (ext_mode[i] ? (ext_pin[i] && !ext_prev[i]) : ext_pin[i])
					ext_flag[i] <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_irq <= '0;
		end else begin
			for (int k = 0; k < N_IRQ_LINES; k++) begin
				ext_irq[k] <= 1'b0;
				for (int i = 0; i < N_EXT; i++) begin
					if (ext_flag[i] && ext_route[2*i +: 2] == 2'(k))
						ext_irq[k] <= 1'b1;
				end
			end
		end
	end

	assign any_irq  = (|ext_irq) || periph_irq;
	// Raw pin levels: detection needs no running clock
	assign wake_req = |(ext_pin & ext_wake);

	////////////////////////////////////////////////////////////////////////////////
	// Power modes

	always_comb begin
		next_state = state;
		unique case (state)
			PWR_RUN: begin
				if (power_mode[DOWN_BIT])
					next_state = PWR_DOWN;
				else if (power_mode[IDLE_BIT])
					next_state = PWR_IDLE;
			end
			PWR_IDLE: begin
				if (any_irq)
					next_state = PWR_RUN;
			end
			PWR_DOWN: begin
				if (wake_req)
					next_state = PWR_WAKE;
			end
			PWR_WAKE: begin
				if (wake_cnt == 16'(WAKE_CYCLES - 1))
					next_state = PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state      <= PWR_RUN;
			wake_cnt   <= '0;
			power_mode <= '0;
			clock_gate <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, osc_en: 1'b1,
				pll_run: 1'b0, pins_hold: 1'b0};
		end else begin
			state    <= next_state;
			wake_cnt <= (state == PWR_WAKE) ? wake_cnt + 16'h0001 : 16'h0000;
			if (wr_hit(OFF_POWER_MODE) && state == PWR_RUN)
				power_mode <= 2'(merged(32'(power_mode)));
			// Mode request self-clears on the way back to run
			if (next_state == PWR_RUN && state != PWR_RUN)
				power_mode <= '0;
			clock_gate.cpu_clk_en <= next_state == PWR_RUN;
			clock_gate.bus_clk_en <= next_state == PWR_RUN;
			clock_gate.osc_en     <= next_state != PWR_DOWN;
			clock_gate.pll_run    <= pll_ctrl[PLL_EN_BIT] &&
				(next_state == PWR_RUN || next_state == PWR_IDLE);
			clock_gate.pins_hold  <= next_state == PWR_DOWN || next_state == PWR_WAKE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Peripheral clock divider and gates

	// Next state, so no pulse leaks into the first power-down cycle
	assign periph_run = next_state == PWR_RUN || next_state == PWR_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pclk_cnt    <= '0;
			pclk_active <= DIV_QUARTER;
			pclk_en     <= 1'b0;
		end else if (!periph_run) begin
			pclk_en <= 1'b0;
		end else if (pclk_cnt == div_terminal(pclk_active)) begin
			// New ratio only taken at a period boundary
			pclk_cnt    <= '0;
			pclk_active <= pclk_div;
			pclk_en     <= 1'b1;
		end else begin
			pclk_cnt <= pclk_cnt + 2'h1;
			pclk_en  <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_clk_gate <= '0;
		end else begin
			periph_clk_gate <= periph_gate & {N_PERIPH{next_state == PWR_RUN ||
				next_state == PWR_IDLE}};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence quarter_pulse;
		pclk_en && div_terminal(pclk_active) == TERM_QUARTER;
	endsequence

	sequence quiet_three;
		!pclk_en [*3];
	endsequence

	a_quarter_no_short: assert property (quarter_pulse |=> quiet_three)
		else $error("peripheral pulse came early at quarter rate");
	a_idle_cpu_stop: assert property (state == PWR_IDLE |-> !clock_gate.cpu_clk_en
		&& !clock_gate.bus_clk_en && clock_gate.osc_en)
		else $error("core or bus clock running in idle");
	a_down_osc_off: assert property (state == PWR_DOWN |-> !clock_gate.osc_en
		&& clock_gate.pins_hold && !pclk_en)
		else $error("clock alive in power-down");
	a_idle_pll_kept: assert property (state == PWR_IDLE && $past(state) == PWR_IDLE
		&& pll_ctrl[PLL_EN_BIT] |-> clock_gate.pll_run)
		else $error("loop stopped during idle");
	a_wake_via_timer: assert property (state == PWR_DOWN |=> state != PWR_RUN)
		else $error("power-down left without wake timer");
	a_idle_exit_irq: assert property (state == PWR_IDLE && any_irq |=> state == PWR_RUN
		##1 clock_gate.cpu_clk_en)
		else $error("interrupt did not end idle");
	a_level3_locked: assert property (level == LVL_THREE && prot_valid |-> !access.debug_en
		&& !access.boot_pin_honored)
		else $error("level three access open");
	a_level_debug_off: assert property (prot_valid && level != LVL_NONE
		|-> !access.debug_en)
		else $error("debug open at protected level");
	a_edge_flag_set: assert property (edge_hit != '0
		|=> (ext_flag & $past(edge_hit)) == $past(edge_hit))
		else $error("edge event lost");
	a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");

endmodule

// ===== test_system_power_protect_ctrl.sv
// Self-checking bench for the system control block
`timescale 1ns/10ps

module test_system_power_protect_ctrl;
	import sys_ctrl_pkg::*;

	localparam int WAKE = 2;

	typedef struct packed {
		logic [31:0] mask;
		logic [31:0] data;
		logic [1:0]  resp;
	} exp_t;

	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, periph_irq, irq_req, pll_lock;
	logic              flash_word_valid, boot_entry_pin, pclk_en, core_clk_from_pll;
	logic              vectors_in_sram, boot_loader_entry;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, flash_protect_word, r;
	logic [3:0]        wstrb, ext_irq;
	logic [1:0]        bresp, rresp;
	logic [8:0]        ext_pin, pin_req;
	logic [15:0]       periph_clk_gate;
	logic [5:0]        acc, msk;
	clock_gate_t       clock_gate;
	access_t           access;
	exp_t              exp_q[$];
	exp_t              e;
	int                n_fail, checks, seed, p, per;
	localparam logic [31:0] PATS [4] = '{32'h0, 32'hA5A5_0001, 32'hA5A5_0002, 32'hA5A5_0003};

	system_power_protect_ctrl #(.WAKE_CYCLES(WAKE), .PATTERN_ONE(PATS[1]),
		.PATTERN_TWO(PATS[2]), .PATTERN_THREE(PATS[3])) dut_u (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ext_pin,
		.periph_irq, .flash_protect_word, .flash_word_valid, .boot_entry_pin, .pll_lock,
		.ext_irq, .clock_gate, .periph_clk_gate, .pclk_en, .core_clk_from_pll,
		.vectors_in_sram, .access, .boot_loader_entry);

	irq_source_model src_u (.aclk, .aresetn, .pin_req, .irq_req,
		.pll_run(clock_gate.pll_run), .ext_pin, .periph_irq, .pll_lock);

	initial begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic timeout();
		n_fail++;
		$display("ERROR %0t wait ran out", $time);
		close_out();
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	// Responses are judged by the watcher, in issue order
	always @(posedge aclk) begin
		if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
			if (exp_q.size() == 0) begin
				n_fail++;
				$display("ERROR %0t response with nothing expected", $time);
			end else begin
				e = exp_q.pop_front();
				if (rvalid) chk(rdata & e.mask, e.data, "rdata");
				chk(32'(rvalid ? rresp : bresp), 32'(e.resp), "resp");
			end
		end
	end

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ag, wg;
		exp_q.push_back('{32'h0, 32'h0, er});
		ag = 1'h0;
		wg = 1'h0;
		n = 0;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (!ag && awready) begin
				ag = 1'h1;
				awvalid <= 1'h0;
			end
			if (!wg && wready) begin
				wg = 1'h1;
				wvalid <= 1'h0;
			end
		end while (!(bvalid && bready) && n < 40);
		bready <= 1'h0;
		if (!(bvalid && bready)) timeout();
		@(posedge aclk);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		exp_q.push_back('{m, d & m, er});
		n = 0;
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'h0;
		end while (!(rvalid && rready) && n < 40);
		rready <= 1'h0;
		if (!(rvalid && rready)) timeout();
		@(posedge aclk);
	endtask

	task automatic boot(input logic [31:0] word, input logic pin);
		aresetn          <= 1'h0;
		flash_word_valid <= 1'h0;
		pin_req          <= 9'h0;
		irq_req          <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn            <= 1'h1;
		flash_protect_word <= word;
		boot_entry_pin     <= pin;
		flash_word_valid   <= 1'h1;
		repeat (3) @(posedge aclk);
	endtask

	// Edges until the next peripheral clock pulse, capped at 20
	task automatic pulse_gap(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!pclk_en && n < 20);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 61;
		n_fail = 0;
		checks = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, irq_req} = 7'h0;
		{flash_word_valid, boot_entry_pin, awaddr, araddr, wstrb, pin_req} = 27'h0;
		wdata = 32'h0;
		flash_protect_word = 32'h0;
		for (int l = 0; l < 4; l++) begin
			boot(PATS[l], 1'h1);
			acc = {l == 0, l != 3, l == 1, l == 2, l != 3, 1'h1};
			msk = (l == 3) ? 6'h33 : 6'h3F;
			chk(32'(access & msk), 32'(acc & msk), "access");
			chk(32'(boot_loader_entry), 32'(l != 3), "boot entry");
			rd(OFF_PROT_STATUS, 32'h7, 32'(4 + l), RESP_OKAY);
			wr(OFF_PROT_STATUS, 32'h0, RESP_SLVERR);
		end
		wr(OFF_BOOT_REQ, 32'h1, RESP_OKAY);
		chk(32'({boot_loader_entry, access.isp_en}), 32'h3, "app boot");
		end_test("protection");
		boot(32'h0, 1'h0);
		chk(32'(clock_gate), 32'h1C, "gates");
		chk(32'({core_clk_from_pll, vectors_in_sram}), 32'h0, "map");
		rd(OFF_PCLK_DIV, 32'h3, 32'h0, RESP_OKAY);
		rd(OFF_PERIPH_GATE, 32'hFFFF, 32'hFFFF, RESP_OKAY);
		pulse_gap(per);
		pulse_gap(per);
		chk(32'(per), 32'h4, "reset ratio");
		end_test("reset");
		for (int k = 1; k < 5; k++) begin
			wr(OFF_PCLK_DIV, 32'(k & 3), RESP_OKAY);
			pulse_gap(per);
			pulse_gap(per);
			chk(32'(per), (k == 1) ? 32'h1 : (k == 2) ? 32'h2 : 32'h4, "ratio");
		end
		r = $random(seed);
		wr(OFF_PERIPH_GATE, r, RESP_OKAY);
		chk(32'(periph_clk_gate), 32'(r[15:0]), "periph gate");
		wr(OFF_VECTOR_MAP, 32'h1, RESP_OKAY);
		chk(32'(vectors_in_sram), 32'h1, "vectors");
		wr(OFF_PLL_CTRL, 32'h1, RESP_OKAY);
		repeat (12) @(posedge aclk);
		rd(OFF_PLL_CTRL, 32'h7, 32'h5, RESP_OKAY);
		chk(32'(core_clk_from_pll), 32'h0, "bypass");
		wr(OFF_PLL_CTRL, 32'h3, RESP_OKAY);
		chk(32'(core_clk_from_pll), 32'h1, "connect");
		end_test("clocks");
		wr(OFF_POWER_MODE, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(32'(clock_gate), 32'h06, "idle gates");
		pulse_gap(per);
		pulse_gap(per);
		chk(32'(per), 32'h4, "idle pclk");
		chk(32'(periph_clk_gate), 32'(r[15:0]), "idle periph");
		irq_req <= 1'h1;
		@(posedge aclk);
		irq_req <= 1'h0;
		repeat (4) @(posedge aclk);
		chk(32'(clock_gate.cpu_clk_en), 32'h1, "idle exit");
		rd(OFF_POWER_MODE, 32'hF, 32'h0, RESP_OKAY);
		end_test("idle");
		wr(OFF_EXT_ROUTE, 32'h0000_E4E4, RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			p = $unsigned($random(seed)) % 9;
			wr(OFF_EXT_MODE, k[0] ? 32'h1FF : 32'h0, RESP_OKAY);
			pin_req <= 9'h1 << p;
			repeat (4) @(posedge aclk);
			chk(32'(ext_irq), 32'h1 << (p % 4), "raise");
			wr(OFF_EXT_FLAG, 32'h1 << p, RESP_OKAY);
			repeat (4) @(posedge aclk);
			chk(32'(ext_irq), k[0] ? 32'h0 : 32'h1 << (p % 4), "held pin");
			pin_req <= 9'h0;
			repeat (3) @(posedge aclk);
			wr(OFF_EXT_FLAG, 32'h1FF, RESP_OKAY);
			repeat (3) @(posedge aclk);
			chk(32'(ext_irq), 32'h0, "cleared");
		end
		end_test("interrupts");
		p = $unsigned($random(seed)) % 9;
		wr(OFF_EXT_WAKE, 32'h1 << p, RESP_OKAY);
		wr(OFF_POWER_MODE, 32'h2, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(32'(clock_gate), 32'h01, "down gates");
		pulse_gap(per);
		chk(32'(per), 32'd20, "no pclk");
		chk(32'(periph_clk_gate), 32'h0, "down gate");
		rd(OFF_PERIPH_GATE, 32'hFFFF, r, RESP_OKAY);
		pin_req <= 9'h1 << p;
		repeat (WAKE + 1) @(posedge aclk);
		chk(32'(clock_gate.cpu_clk_en), 32'h0, "wake timer");
		per = 0;
		while (!clock_gate.cpu_clk_en && per < 8) begin
			@(posedge aclk);
			per++;
		end
		chk(32'(clock_gate.cpu_clk_en), 32'h1, "woken");
		chk(32'(periph_clk_gate), 32'(r[15:0]), "gate back");
		pin_req <= 9'h0;
		rd(OFF_POWER_MODE, 32'hF, 32'h0, RESP_OKAY);
		rd(6'h2C, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
		wr(6'h02, 32'h0, RESP_SLVERR);
		chk(32'(access.iap_en), 32'h1, "iap");
		end_test("power down");
		close_out();
	end
endmodule
